// *** agu_transfer_unit.sv ***
`include "agu_cfg.svh"

module agu_transfer_unit
	import agu_pkg::*;
#(
	parameter int MAX_INST_LEN = `AGU_MAX_INST_LEN
)
(
	input  wire logic    clk,
	input  wire logic    rst,
	input  wire logic    ce,
	input  wire logic    req_valid,
	input  agu_req_type  req,
	output logic         req_ready,
	input  wire logic    mem_ready,
	input  wire logic [31:0] mem_rdata,
	output agu_mem_type  mem,
	output logic [`AGU_REG_W-1:0] blk_rd_idx,
	input  wire logic [31:0] blk_rd_data,
	output agu_wb_type   wb,
	output logic [31:0]  operand,
	output logic [31:0]  target,
	output logic [31:0]  next_pc,
	output logic         done,
	output logic         misalign_exc,
	output logic         illegal
);

	// Refuse lengths that the three-bit length field cannot hold
	if (MAX_INST_LEN < 1 || MAX_INST_LEN > 7) begin : g_bad_len
		$error("MAX_INST_LEN must lie in 1..7");
	end

	localparam logic [2:0] MAX_LEN = 3'(MAX_INST_LEN);

	agu_state_type              state;
	logic [31:0]                acc_addr;
	agu_size_type               acc_size;
	logic                       acc_store;
	logic                       acc_pref;
	logic                       acc_post;
	logic [`AGU_REG_W-1:0]      acc_idx;
	logic [`AGU_REG_W-1:0]      acc_base_idx;
	logic [31:0]                acc_base;
	logic [`AGU_NUM_REGS-1:0]   blk_mask;
	logic [31:0]                blk_addr;
	logic [31:0]                blk_final;
	logic                       blk_store;

	logic                       accept;
	logic                       mem_done;
	logic                       imm_sgn;
	logic [31:0]                imm_ext;
	logic [31:0]                ea;
	logic                       mem_mode;
	logic                       bad;
	agu_size_type               op_size;
	logic                       is_mem_op;
	logic [31:0]                step;
	agu_size_type               wid_size;
	logic                       wid_sgn;
	logic [31:0]                wid_out;
	logic [1:0]                 lane_addr;
	agu_size_type               lane_size;
	logic [31:0]                lane_wd;
	logic [3:0]                 lane_be;
	logic [31:0]                lane_wp;
	logic [31:0]                lane_rraw;
	logic                       lane_mis;
	logic [31:0]                load_ext;
	logic                       mis_now;
	logic [31:0]                blk_span;
	logic [`AGU_NUM_REGS-1:0]   blk_rest;

	function automatic logic [31:0] count_bits(input logic [`AGU_NUM_REGS-1:0] m);
		logic [31:0] n;
		n = `AGU_ZERO_WORD;
		for (int i = 0; i < `AGU_NUM_REGS; i++)
			n = n + 32'(m[i]);
		return n;
	endfunction

	function automatic logic [`AGU_REG_W-1:0] lowest_bit(input logic [`AGU_NUM_REGS-1:0] m);
		logic [`AGU_REG_W-1:0] k;
		k = '0;
		for (int i = `AGU_NUM_REGS - 1; i >= 0; i--)
			if (m[i])
				k = `AGU_REG_W'(i);
		return k;
	endfunction

	assign accept   = ce & req_ready & req_valid;
	assign mem_done = ce & mem.req & mem_ready;

	always_comb begin
		imm_sgn = !(req.mode == AGU_AM_REL_SP || req.mode == AGU_AM_ABS
			|| req.op == AGU_OP_UIMM);
		case (req.mode)
			AGU_AM_IND,
			AGU_AM_POSTINC: ea = req.base;
			AGU_AM_REL_REG: ea = req.base + imm_ext;
			AGU_AM_REL_SP:  ea = req.sp + imm_ext;
			AGU_AM_REL_PC:  ea = req.pc + imm_ext;
			AGU_AM_ABS:     ea = imm_ext;
			AGU_AM_INDEXED: ea = req.base + req.index;
			default:        ea = `AGU_ZERO_WORD;
		endcase
		mem_mode = req.mode inside {AGU_AM_IND, AGU_AM_POSTINC, AGU_AM_REL_REG,
			AGU_AM_REL_SP, AGU_AM_ABS, AGU_AM_INDEXED};
		case (req.op)
			AGU_OP_HALF: op_size = AGU_SZ_HALF;
			AGU_OP_BYTE: op_size = AGU_SZ_BYTE;
			default:     op_size = AGU_SZ_WORD;
		endcase
		case (req.op)
			AGU_OP_HALF: step = `AGU_STEP_HALF;
			AGU_OP_BYTE: step = `AGU_STEP_BYTE;
			default:     step = `AGU_STEP_WORD;
		endcase
		is_mem_op = mem_mode && req.op inside {AGU_OP_WORD, AGU_OP_HALF,
			AGU_OP_BYTE, AGU_OP_PREF};
		bad = 1'b0;
		if (req.inst_len < `AGU_MIN_INST_LEN || req.inst_len > MAX_LEN)
			bad = 1'b1;
		if ((req.mode == AGU_AM_REL_PC) != (req.op == AGU_OP_BRANCH))
			bad = 1'b1;
		case (req.op)
			AGU_OP_WORD:    bad = bad | (req.mode == AGU_AM_REL_PC);
			AGU_OP_UIMM:    bad = bad | (req.mode != AGU_AM_IMM);
			AGU_OP_HALF:    bad = bad | !mem_mode;
			AGU_OP_BYTE,
			AGU_OP_PREF:    bad = bad | !mem_mode | (req.mode == AGU_AM_POSTINC);
			AGU_OP_BLOCK:   bad = bad | (req.reg_mask == '0);
			AGU_OP_REGOP:   bad = bad | !(req.mode inside {AGU_AM_REG, AGU_AM_IMM});
			AGU_OP_BRANCH:  bad = bad | (req.imm_size == AGU_SZ_TRIPLE);
			AGU_OP_WID_W, AGU_OP_WID_HS, AGU_OP_WID_HU, AGU_OP_WID_BS, AGU_OP_WID_BU,
			AGU_OP_ZERO:    bad = bad | (req.mode != AGU_AM_REG);
			default:        bad = 1'b1;
		endcase
		case (req.op)
			AGU_OP_WID_HS: wid_size = AGU_SZ_HALF;
			AGU_OP_WID_HU: wid_size = AGU_SZ_HALF;
			AGU_OP_WID_BS: wid_size = AGU_SZ_BYTE;
			AGU_OP_WID_BU: wid_size = AGU_SZ_BYTE;
			default:       wid_size = AGU_SZ_WORD;
		endcase
		wid_sgn = req.op == AGU_OP_WID_HS || req.op == AGU_OP_WID_BS;
		case (state)
			AGU_ST_IDLE: begin
				lane_addr = ea[1:0];
				lane_size = op_size;
			end
			AGU_ST_MEM: begin
				lane_addr = acc_addr[1:0];
				lane_size = acc_size;
			end
			default: begin
				lane_addr = 2'h0;
				lane_size = AGU_SZ_WORD;
			end
		endcase
		lane_wd = (state == AGU_ST_BLK_ISSUE) ? blk_rd_data : req.src;
		if (req.op == AGU_OP_BLOCK)
			mis_now = |req.sp[1:0];
		else
			mis_now = is_mem_op && req.op != AGU_OP_PREF && lane_mis;
		blk_span = 32'(count_bits(req.reg_mask) << 2);
		blk_rest = blk_mask & ~(`AGU_NUM_REGS'(1) << blk_rd_idx);
	end

	agu_widen u_imm_widen (
		.raw  (req.imm),
		.size (req.imm_size),
		.sgn  (imm_sgn),
		.wide (imm_ext)
	);

	agu_widen u_op_widen (
		.raw  (req.src),
		.size (wid_size),
		.sgn  (wid_sgn),
		.wide (wid_out)
	);

	agu_widen u_load_widen (
		.raw  (lane_rraw),
		.size (acc_size),
		.sgn  (1'b0),
		.wide (load_ext)
	);

	agu_lane u_lane (
		.addr_lo  (lane_addr),
		.size     (lane_size),
		.wdata    (lane_wd),
		.rdata    (mem_rdata),
		.be       (lane_be),
		.wplaced  (lane_wp),
		.rraw     (lane_rraw),
		.misalign (lane_mis)
	);

	// Sequencing of single accesses and block walks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state        <= AGU_ST_IDLE;
			req_ready    <= 1'b1;
			acc_addr     <= `AGU_ZERO_WORD;
			acc_size     <= AGU_SZ_WORD;
			acc_store    <= 1'b0;
			acc_pref     <= 1'b0;
			acc_post     <= 1'b0;
			acc_idx      <= '0;
			acc_base_idx <= '0;
			acc_base     <= `AGU_ZERO_WORD;
			blk_mask     <= '0;
			blk_addr     <= `AGU_ZERO_WORD;
			blk_final    <= `AGU_ZERO_WORD;
			blk_store    <= 1'b0;
			blk_rd_idx   <= '0;
		end else if (ce) begin
			case (state)
				AGU_ST_IDLE: begin
					if (accept && !bad && !mis_now && is_mem_op) begin
						state        <= AGU_ST_MEM;
						req_ready    <= 1'b0;
						acc_addr     <= ea;
						acc_size     <= op_size;
						acc_store    <= req.store;
						acc_pref     <= req.op == AGU_OP_PREF;
						acc_post     <= req.mode == AGU_AM_POSTINC;
						acc_idx      <= req.dest_idx;
						acc_base_idx <= req.base_idx;
						acc_base     <= req.base + step;
					end else if (accept && !bad && !mis_now && req.op == AGU_OP_BLOCK) begin
						state     <= AGU_ST_BLK_SEL;
						req_ready <= 1'b0;
						blk_mask  <= req.reg_mask;
						blk_store <= req.store;
						blk_addr  <= req.store ? req.sp - blk_span : req.sp;
						blk_final <= req.store ? req.sp - blk_span : req.sp + blk_span;
					end
				end
				AGU_ST_MEM: begin
					if (mem_done) begin
						state     <= AGU_ST_IDLE;
						req_ready <= 1'b1;
					end
				end
				AGU_ST_BLK_SEL: begin
					blk_rd_idx <= lowest_bit(blk_mask);
					state      <= AGU_ST_BLK_ISSUE;
				end
				AGU_ST_BLK_ISSUE: begin
					if (mem_done) begin
						blk_mask <= blk_rest;
						blk_addr <= blk_addr + `AGU_BLK_STEP;
						if (blk_rest == '0) begin
							state     <= AGU_ST_IDLE;
							req_ready <= 1'b1;
						end else begin
							state <= AGU_ST_BLK_SEL;
						end
					end
				end
				default: begin
					state     <= AGU_ST_IDLE;
					req_ready <= 1'b1;
				end
			endcase
		end
	end

	// Memory request port; held until the port answers ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem <= '0;
		end else if (ce) begin
			if (mem_done)
				mem.req <= 1'b0;
			if (state == AGU_ST_IDLE && accept && !bad && !mis_now && is_mem_op) begin
				mem.req      <= 1'b1;
				mem.we       <= req.store && req.op != AGU_OP_PREF;
				mem.prefetch <= req.op == AGU_OP_PREF;
				mem.addr     <= ea;
				mem.be       <= lane_be;
				mem.wdata    <= lane_wp;
			end else if (state == AGU_ST_BLK_ISSUE && !mem.req) begin
				mem.req      <= 1'b1;
				mem.we       <= blk_store;
				mem.prefetch <= 1'b0;
				mem.addr     <= blk_addr;
				mem.be       <= `AGU_BE_WORD;
				mem.wdata    <= lane_wp;
			end
		end
	end

	// Register file write-back, all one-cycle pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb <= '0;
		end else if (ce) begin
			wb.en     <= 1'b0;
			wb.hi_en  <= 1'b0;
			wb.upd_en <= 1'b0;
			if (state == AGU_ST_IDLE && accept && !bad && !is_mem_op) begin
				wb.idx    <= req.dest_idx;
				wb.hi_idx <= req.dest_idx + `AGU_REG_W'(1);
				case (req.op)
					AGU_OP_WORD: begin
						wb.en   <= 1'b1;
						wb.data <= (req.mode == AGU_AM_IMM) ? imm_ext : req.src;
					end
					AGU_OP_UIMM: begin
						wb.en   <= 1'b1;
						wb.data <= imm_ext;
					end
					AGU_OP_WID_W: begin
						wb.en      <= 1'b1;
						wb.data    <= req.src;
						wb.hi_en   <= 1'b1;
						wb.hi_data <= {32{req.src[31]}};
					end
					AGU_OP_WID_HS, AGU_OP_WID_HU, AGU_OP_WID_BS, AGU_OP_WID_BU: begin
						wb.en   <= 1'b1;
						wb.data <= wid_out;
					end
					AGU_OP_ZERO: begin
						wb.en   <= 1'b1;
						wb.data <= `AGU_ZERO_WORD;
					end
					default: wb.en <= 1'b0;
				endcase
			end
			if (state == AGU_ST_MEM && mem_done) begin
				wb.en       <= !acc_store && !acc_pref;
				wb.idx      <= acc_idx;
				wb.data     <= load_ext;
				wb.upd_en   <= acc_post;
				wb.upd_idx  <= acc_base_idx;
				wb.upd_data <= acc_base;
			end
			if (state == AGU_ST_BLK_ISSUE && mem_done) begin
				wb.en       <= !blk_store;
				wb.idx      <= blk_rd_idx;
				wb.data     <= mem_rdata;
				wb.upd_en   <= blk_rest == '0;
				wb.upd_idx  <= `AGU_SP_IDX;
				wb.upd_data <= blk_final;
			end
		end
	end

	// Completion, exceptions and non-memory results
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done         <= 1'b0;
			misalign_exc <= 1'b0;
			illegal      <= 1'b0;
			operand      <= `AGU_ZERO_WORD;
			target       <= `AGU_ZERO_WORD;
			next_pc      <= `AGU_ZERO_WORD;
		end else if (ce) begin
			done         <= 1'b0;
			misalign_exc <= 1'b0;
			illegal      <= 1'b0;
			if (accept) begin
				illegal      <= bad;
				misalign_exc <= !bad && mis_now;
				done         <= !bad && !is_mem_op && req.op != AGU_OP_BLOCK;
				next_pc      <= req.pc + 32'(req.inst_len);
				if (!bad && req.op == AGU_OP_REGOP)
					operand <= (req.mode == AGU_AM_IMM) ? imm_ext : req.src;
				if (!bad && req.op == AGU_OP_BRANCH)
					target <= ea;
			end
			if (state == AGU_ST_MEM && mem_done)
				done <= 1'b1;
			if (state == AGU_ST_BLK_ISSUE && mem_done && blk_rest == '0)
				done <= 1'b1;
		end
	end

endmodule

// *** agu_cfg.svh ***
`ifndef AGU_CFG_SVH
`define AGU_CFG_SVH

// Register file geometry
`define AGU_REG_W        4
`define AGU_NUM_REGS     16
`define AGU_SP_IDX       4'hF

// Instruction length in whole bytes
`define AGU_MIN_INST_LEN 3'h1
`define AGU_MAX_INST_LEN 7

// Post-increment and block steps in bytes
`define AGU_STEP_WORD    32'h00000004
`define AGU_STEP_HALF    32'h00000002
`define AGU_STEP_BYTE    32'h00000001
`define AGU_BLK_STEP     32'h00000004

// Byte enables for an access at lane zero
`define AGU_BE_WORD      4'hF
`define AGU_BE_HALF      4'h3
`define AGU_BE_BYTE      4'h1

`define AGU_ZERO_WORD    32'h00000000

`endif

// *** agu_pkg.sv ***
`include "agu_cfg.svh"

package agu_pkg;

	typedef enum logic [1:0] {
		AGU_SZ_BYTE   = 2'h0,
		AGU_SZ_HALF   = 2'h1,
		AGU_SZ_TRIPLE = 2'h2,
		AGU_SZ_WORD   = 2'h3
	} agu_size_type;

	typedef enum logic [3:0] {
		AGU_OP_WORD    = 4'h0,
		AGU_OP_UIMM    = 4'h1,
		AGU_OP_HALF    = 4'h2,
		AGU_OP_BYTE    = 4'h3,
		AGU_OP_BLOCK   = 4'h4,
		AGU_OP_WID_W   = 4'h5,
		AGU_OP_WID_HS  = 4'h6,
		AGU_OP_WID_HU  = 4'h7,
		AGU_OP_WID_BS  = 4'h8,
		AGU_OP_WID_BU  = 4'h9,
		AGU_OP_ZERO    = 4'hA,
		AGU_OP_PREF    = 4'hB,
		AGU_OP_REGOP   = 4'hC,
		AGU_OP_BRANCH  = 4'hD
	} agu_op_type;

	typedef enum logic [3:0] {
		AGU_AM_REG     = 4'h0,
		AGU_AM_IMM     = 4'h1,
		AGU_AM_IND     = 4'h2,
		AGU_AM_POSTINC = 4'h3,
		AGU_AM_REL_REG = 4'h4,
		AGU_AM_REL_SP  = 4'h5,
		AGU_AM_REL_PC  = 4'h6,
		AGU_AM_ABS     = 4'h7,
		AGU_AM_INDEXED = 4'h8
	} agu_mode_type;

	typedef enum logic [1:0] {
		AGU_ST_IDLE      = 2'h0,
		AGU_ST_MEM       = 2'h1,
		AGU_ST_BLK_SEL   = 2'h2,
		AGU_ST_BLK_ISSUE = 2'h3
	} agu_state_type;

	typedef struct packed {
		agu_op_type               op;
		agu_mode_type             mode;
		logic                     store;
		agu_size_type             imm_size;
		logic [31:0]              imm;
		logic [2:0]               inst_len;
		logic [`AGU_REG_W-1:0]    base_idx;
		logic [`AGU_REG_W-1:0]    dest_idx;
		logic [31:0]              base;
		logic [31:0]              index;
		logic [31:0]              src;
		logic [31:0]              pc;
		logic [31:0]              sp;
		logic [`AGU_NUM_REGS-1:0] reg_mask;
	} agu_req_type;

	typedef struct packed {
		logic                  en;
		logic [`AGU_REG_W-1:0] idx;
		logic [31:0]           data;
		logic                  hi_en;
		logic [`AGU_REG_W-1:0] hi_idx;
		logic [31:0]           hi_data;
		logic                  upd_en;
		logic [`AGU_REG_W-1:0] upd_idx;
		logic [31:0]           upd_data;
	} agu_wb_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        prefetch;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} agu_mem_type;

endpackage

// *** agu_widen.sv ***
`include "agu_cfg.svh"

module agu_widen
	import agu_pkg::*;
(
	input  wire logic [31:0]  raw,
	input  agu_size_type      size,
	input  wire logic         sgn,
	output logic [31:0]       wide
);

	always_comb begin
		case (size)
			AGU_SZ_BYTE:   wide = {{24{sgn & raw[7]}}, raw[7:0]};
			AGU_SZ_HALF:   wide = {{16{sgn & raw[15]}}, raw[15:0]};
			AGU_SZ_TRIPLE: wide = {{8{sgn & raw[23]}}, raw[23:0]};
			default:       wide = raw;
		endcase
	end

endmodule

// *** agu_lane.sv ***
`include "agu_cfg.svh"

module agu_lane
	import agu_pkg::*;
(
	input  wire logic [1:0]  addr_lo,
	input  agu_size_type     size,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] rdata,
	output logic [3:0]       be,
	output logic [31:0]      wplaced,
	output logic [31:0]      rraw,
	output logic             misalign
);

	// Little-endian lanes: byte at 4n sits in bits 7:0, byte at 4n+3 in 31:24
	always_comb begin
		case (size)
			AGU_SZ_BYTE: be = 4'(`AGU_BE_BYTE << addr_lo);
			AGU_SZ_HALF: be = 4'(`AGU_BE_HALF << addr_lo);
			default:     be = `AGU_BE_WORD;
		endcase
		wplaced  = 32'(wdata << {addr_lo, 3'h0});
		rraw     = 32'(rdata >> {addr_lo, 3'h0});
		case (size)
			AGU_SZ_BYTE: misalign = 1'b0;
			AGU_SZ_HALF: misalign = addr_lo[0];
			default:     misalign = |addr_lo;
		endcase
	end

endmodule

// *** agu_transfer_unit_props.sv ***
`include "agu_cfg.svh"

module agu_transfer_unit_props
	import agu_pkg::*;
#(
	parameter int MAX_INST_LEN = `AGU_MAX_INST_LEN
)
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 ce,
	input wire logic                 req_valid,
	input agu_req_type               req,
	input wire logic                 req_ready,
	input wire logic                 mem_ready,
	input wire logic [31:0]          mem_rdata,
	input agu_mem_type               mem,
	input wire logic [`AGU_REG_W-1:0] blk_rd_idx,
	input wire logic [31:0]          blk_rd_data,
	input agu_wb_type                wb,
	input wire logic [31:0]          operand,
	input wire logic [31:0]          target,
	input wire logic [31:0]          next_pc,
	input wire logic                 done,
	input wire logic                 misalign_exc,
	input wire logic                 illegal
);
	logic acc;
	logic ok;
	assign acc = ce && req_valid && req_ready;
	assign ok = acc && req.inst_len != 3'h0 && req.inst_len <= MAX_INST_LEN;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	zero_write_a: assert property (ok && req.op == AGU_OP_ZERO && req.mode == AGU_AM_REG
		|-> ##1 wb.en && wb.data == 32'h0 && done) else $error("clear did not write zero");
	byte_sign_a: assert property (ok && req.op == AGU_OP_WID_BS && req.mode == AGU_AM_REG
		|-> ##1 wb.en && wb.data == {{24{$past(req.src[7])}}, $past(req.src[7:0])})
		else $error("signed byte widen wrong");
	half_zero_a: assert property (ok && req.op == AGU_OP_WID_HU && req.mode == AGU_AM_REG
		|-> ##1 wb.en && wb.data == {16'h0, $past(req.src[15:0])})
		else $error("unsigned half widen wrong");
	pair_high_a: assert property (ok && req.op == AGU_OP_WID_W && req.mode == AGU_AM_REG
		|-> ##1 wb.hi_en && wb.hi_data == {32{$past(req.src[31])}}
		&& wb.hi_idx == $past(req.dest_idx) + 4'h1) else $error("word widen high half wrong");
	len_refuse_a: assert property (acc && req.inst_len == 3'h0
		|-> ##1 illegal && !done && !wb.en) else $error("zero length not refused");
	pc_rel_a: assert property (ok && req.mode == AGU_AM_REL_PC && req.op != AGU_OP_BRANCH
		|-> ##1 illegal && !mem.req) else $error("pc relative taken outside branch");
	regop_nomem_a: assert property (acc && req.op == AGU_OP_REGOP
		|-> ##1 !mem.req [*3]) else $error("register op reached memory");
	req_hold_a: assert property (mem.req && !mem_ready
		|-> ##1 mem.req && $stable(mem.addr) && $stable(mem.wdata))
		else $error("memory request dropped or changed");
	word_align_a: assert property (mem.req && !mem.prefetch && mem.be == 4'hF
		|-> mem.addr[1:0] == 2'h0) else $error("misaligned word issued");
	pref_nowb_a: assert property (mem.req && mem.prefetch && mem_ready
		|-> ##1 !wb.en && done) else $error("prefetch wrote a register");
	next_pc_a: assert property (ok && req.op == AGU_OP_WORD && req.mode == AGU_AM_REG
		|-> ##1 next_pc == $past(req.pc) + {29'h0, $past(req.inst_len)})
		else $error("next pc wrong");

	cov_block: cover property (mem.req && mem_ready && !mem.prefetch ##1 done && wb.upd_en);
	cov_misal: cover property (misalign_exc);
	cov_pair: cover property (wb.hi_en);
endmodule

bind agu_transfer_unit agu_transfer_unit_props #(.MAX_INST_LEN(MAX_INST_LEN)) i_props (
	.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
	.req_ready(req_ready), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem(mem),
	.blk_rd_idx(blk_rd_idx), .blk_rd_data(blk_rd_data), .wb(wb), .operand(operand),
	.target(target), .next_pc(next_pc), .done(done), .misalign_exc(misalign_exc),
	.illegal(illegal));

// *** agu_mem_model.sv ***
module agu_mem_model
	import agu_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input agu_mem_type     mem,
	input wire logic [3:0] lat,
	output logic           mem_ready,
	output logic [31:0]    mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  m [0:255];
	logic [3:0]  cnt;
	logic [31:0] last;
	logic [7:0]  a;
	logic [31:0] word;

	assign a = {mem.addr[7:2], 2'h0};
	assign word = {m[a + 8'h3], m[a + 8'h2], m[a + 8'h1], m[a]};
	// Between answers the data lines show the inverse of the last word
	assign mem_rdata = mem_ready ? word : ~last;

	initial begin
		for (int i = 0; i < 256; i++) m[i] = i[7:0];
	end

	// Ready comes lat+1 cycles after the request shows, one cycle wide
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			mem_ready <= 1'b0;
		end else if (mem.req && !mem_ready) begin
			if (cnt >= lat) begin
				mem_ready <= 1'b1;
				cnt <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			mem_ready <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (mem_ready) begin
			last <= word;
		end
		if (mem.req && mem_ready && mem.we) begin
			for (int b = 0; b < 4; b++) begin
				if (mem.be[b]) begin
					m[a + 8'(b)] <= mem.wdata[8*b +: 8];
				end
			end
		end
	end
endmodule

// *** tb.sv ***
`include "agu_cfg.svh"

module tb
	import agu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clk;
	logic                  rst;
	logic                  ce;
	logic                  req_valid;
	agu_req_type           req;
	logic                  req_ready;
	logic                  mem_ready;
	logic [31:0]           mem_rdata;
	agu_mem_type           mem;
	logic [`AGU_REG_W-1:0] blk_rd_idx;
	logic [31:0]           blk_rd_data;
	agu_wb_type            wb;
	logic [31:0]           operand;
	logic [31:0]           target;
	logic [31:0]           next_pc;
	logic                  done;
	logic                  misalign_exc;
	logic                  illegal;
	logic [3:0]            lat;
	int                    num_errors;
	int                    cmp_count;
	agu_wb_type            w;
	logic [31:0]           ad;
	logic                  sen;
	logic                  spf;
	logic                  srq;
	logic                  il;
	logic                  ms;

	assign blk_rd_data = {28'hA000000, blk_rd_idx};

	agu_transfer_unit i_dut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem(mem),
		.blk_rd_idx(blk_rd_idx), .blk_rd_data(blk_rd_data), .wb(wb), .operand(operand),
		.target(target), .next_pc(next_pc), .done(done), .misalign_exc(misalign_exc),
		.illegal(illegal));
	agu_mem_model i_mem (.clk(clk), .rst(rst), .mem(mem), .lat(lat),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] rd(input logic [7:0] a);
		rd = {i_mem.m[a + 8'h3], i_mem.m[a + 8'h2], i_mem.m[a + 8'h1], i_mem.m[a]};
	endfunction

	function automatic agu_req_type mk(input agu_op_type op, input agu_mode_type md,
		input logic [31:0] v);
		agu_req_type r;
		r = '0;
		r.op = op;
		r.mode = md;
		r.imm_size = AGU_SZ_HALF;
		r.imm = 32'h00008F00;
		r.inst_len = 3'h3;
		r.base_idx = 4'h6;
		r.dest_idx = 4'h2;
		r.base = v;
		r.src = v;
		r.pc = 32'h00001000;
		r.sp = 32'h00000080;
		return r;
	endfunction

	// Issue one request and wait for its end, noting what the memory side saw
	task automatic run(input agu_req_type r);
		sen = 1'b0;
		spf = 1'b0;
		srq = 1'b0;
		@(negedge clk);
		chk({31'h0, req_ready}, 32'h1);
		req = r;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		for (int i = 0; i < 80; i++) begin
			if (mem.req === 1'b1) begin
				ad = mem.addr;
				spf = mem.prefetch;
				srq = 1'b1;
			end
			if (wb.en === 1'b1) sen = 1'b1;
			if ((done | illegal | misalign_exc) === 1'b1) begin
				w = wb;
				il = illegal;
				ms = misalign_exc;
				return;
			end
			@(negedge clk);
		end
		num_errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	endtask

	task automatic reg_case(input agu_op_type op, input agu_mode_type md, input logic [31:0] e);
		run(mk(op, md, 32'h923480F0));
		chk(w.data, e);
		chk({31'h0, srq}, 32'h0);
	endtask

	task automatic t_regs();
		reg_case(AGU_OP_WORD, AGU_AM_REG, 32'h923480F0);
		reg_case(AGU_OP_WORD, AGU_AM_IMM, 32'hFFFF8F00);
		reg_case(AGU_OP_UIMM, AGU_AM_IMM, 32'h00008F00);
		reg_case(AGU_OP_WID_HS, AGU_AM_REG, 32'hFFFF80F0);
		reg_case(AGU_OP_WID_HU, AGU_AM_REG, 32'h000080F0);
		reg_case(AGU_OP_WID_BS, AGU_AM_REG, 32'hFFFFFFF0);
		reg_case(AGU_OP_WID_BU, AGU_AM_REG, 32'h000000F0);
		reg_case(AGU_OP_ZERO, AGU_AM_REG, 32'h0);
		reg_case(AGU_OP_WID_W, AGU_AM_REG, 32'h923480F0);
		chk(w.hi_data, 32'hFFFFFFFF);
		chk({28'h0, w.hi_idx}, 32'h3);
		$display("test regs finished");
	endtask

	task automatic t_mem();
		agu_req_type r;
		r = mk(AGU_OP_WORD, AGU_AM_IND, 32'h40);
		r.store = 1'b1;
		r.src = 32'h11223344;
		run(r);
		chk({24'h0, i_mem.m[8'h40]}, 32'h44);
		chk(rd(8'h40), 32'h11223344);
		run(mk(AGU_OP_HALF, AGU_AM_POSTINC, 32'h42));
		chk(w.data, 32'h00001122);
		chk(w.upd_data, 32'h44);
		run(mk(AGU_OP_BYTE, AGU_AM_IND, 32'h43));
		chk(w.data, 32'h11);
		lat = 4'h0;
		run(mk(AGU_OP_WORD, AGU_AM_POSTINC, 32'h40));
		chk(w.data, 32'h11223344);
		chk(w.upd_data, 32'h44);
		r = mk(AGU_OP_HALF, AGU_AM_IND, 32'h46);
		r.store = 1'b1;
		r.src = 32'h0000BEEF;
		run(r);
		chk(rd(8'h44), 32'hBEEF4544);
		$display("test mem finished");
	endtask

	task automatic t_addr();
		agu_req_type r;
		r = mk(AGU_OP_WORD, AGU_AM_REL_REG, 32'h80);
		r.imm = 32'h000000FC;
		r.imm_size = AGU_SZ_BYTE;
		run(r);
		chk(ad, 32'h7C);
		chk(w.data, 32'h7F7E7D7C);
		r.mode = AGU_AM_REL_SP;
		run(r);
		chk(ad, 32'h17C);
		r.mode = AGU_AM_ABS;
		r.imm = 32'h0000FF80;
		r.imm_size = AGU_SZ_HALF;
		run(r);
		chk(ad, 32'hFF80);
		r = mk(AGU_OP_WORD, AGU_AM_INDEXED, 32'h40);
		r.index = 32'h20;
		run(r);
		chk(ad, 32'h60);
		r.mode = AGU_AM_REL_PC;
		run(r);
		chk({31'h0, il}, 32'h1);
		r = mk(AGU_OP_BRANCH, AGU_AM_REL_PC, 32'h0);
		r.imm = 32'h000000F0;
		r.imm_size = AGU_SZ_BYTE;
		run(r);
		chk(target, 32'h00000FF0);
		$display("test addr finished");
	endtask

	task automatic t_refuse();
		agu_req_type r;
		run(mk(AGU_OP_WORD, AGU_AM_IND, 32'h41));
		chk({30'h0, ms, srq}, 32'h2);
		run(mk(AGU_OP_HALF, AGU_AM_IND, 32'h43));
		chk({30'h0, ms, srq}, 32'h2);
		r = mk(AGU_OP_WORD, AGU_AM_REG, 32'h5);
		r.inst_len = 3'h0;
		run(r);
		chk({31'h0, il}, 32'h1);
		r.inst_len = 3'h1;
		r.pc = 32'h00002000;
		run(r);
		chk(next_pc, 32'h00002001);
		r = mk(AGU_OP_REGOP, AGU_AM_IND, 32'h40);
		run(r);
		chk({31'h0, il}, 32'h1);
		r.mode = AGU_AM_IMM;
		run(r);
		chk(operand, 32'hFFFF8F00);
		chk({31'h0, srq}, 32'h0);
		$display("test refuse finished");
	endtask

	task automatic t_block();
		agu_req_type r;
		lat = 4'h2;
		r = mk(AGU_OP_BLOCK, AGU_AM_REG, 32'h0);
		r.reg_mask = 16'h002A;
		r.store = 1'b1;
		run(r);
		chk(rd(8'h74), 32'hA0000001);
		chk(rd(8'h78), 32'hA0000003);
		chk(rd(8'h7C), 32'hA0000005);
		chk(w.upd_data, 32'h74);
		r.store = 1'b0;
		r.sp = 32'h74;
		run(r);
		chk(w.data, 32'hA0000005);
		chk({28'h0, w.idx}, 32'h5);
		chk(w.upd_data, 32'h80);
		run(mk(AGU_OP_PREF, AGU_AM_IND, 32'h43));
		chk({30'h0, spf, sen}, 32'h2);
		$display("test block finished");
	endtask

	// A request offered while the enable is low must not be taken
	task automatic t_freeze();
		@(negedge clk);
		ce = 1'b0;
		req = mk(AGU_OP_ZERO, AGU_AM_REG, 32'h1);
		req.pc = 32'h00003000;
		req_valid = 1'b1;
		@(negedge clk);
		chk({31'h0, done}, 32'h0);
		chk(next_pc, 32'h00001003);
		req_valid = 1'b0;
		ce = 1'b1;
		$display("test freeze finished");
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		req_valid = 1'b0;
		req = '0;
		lat = 4'h3;
		num_errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_regs();
		t_mem();
		t_addr();
		t_refuse();
		t_block();
		t_freeze();
		conclude();
	end
endmodule
